// ### hdl/ser_group.sv
// One status group: filters, sticky events, enable mask, summary
`include "ser_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ser_group (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic clk_en,
	ser_grp_if.grp    g
);
	ser_pkg::ser_word_t cond_prev_r, event_r, ena_r, fall_r, rise_r;
	ser_pkg::ser_word_t cond_prev_nxt, event_nxt, ena_nxt, fall_nxt, rise_nxt;
	ser_pkg::ser_word_t hit;

	// Edge detect and sticky capture; a new hit survives a clearing read
	always_comb
	begin
		hit = ((g.cond & ~cond_prev_r & rise_r) | (~g.cond & cond_prev_r & fall_r))
			& `SER_LIVE_MASK; // [R12] [R13]
		cond_prev_nxt = g.cond & `SER_LIVE_MASK;
		event_nxt = (g.rd_clr ? `SER_ZERO : event_r) | hit; // [R5] [R6] [R7]
		ena_nxt  = g.wr_ena  ? (g.wr_data & `SER_LIVE_MASK) : ena_r; // [R14]
		fall_nxt = g.wr_fall ? (g.wr_data & `SER_LIVE_MASK) : fall_r;
		rise_nxt = g.wr_rise ? (g.wr_data & `SER_LIVE_MASK) : rise_r;
		if (g.preset)
		begin
			ena_nxt = `SER_ZERO; // [R15]
			fall_nxt = `SER_ZERO;
			rise_nxt = `SER_ZERO;
			event_nxt = hit;
		end
	end

	// Registered state of the group
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cond_prev_r <= `SER_ZERO;
			event_r <= `SER_ZERO;
			ena_r <= `SER_ZERO; // [R14]
			fall_r <= `SER_ZERO;
			rise_r <= `SER_ZERO;
		end
		else if (clk_en)
		begin
			cond_prev_r <= cond_prev_nxt;
			event_r <= event_nxt;
			ena_r <= ena_nxt;
			fall_r <= fall_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign g.event_q = event_r; // [R1]
	assign g.ena_q   = ena_r;
	assign g.fall_q  = fall_r;
	assign g.rise_q  = rise_r;
	assign g.summary = |(event_r & ena_r); // [R16]

	// Hit must be recorded next cycle even under a clearing read
	a_hit_kept_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && hit != 16'h0000 |=> (event_r & $past(hit)) == $past(hit)) // [R6]
		else $error("event lost on clear");
	a_msb_stays_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		!event_r[15] && !ena_r[15]) // [R4]
		else $error("unused bit set");
	a_clear_on_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && g.rd_clr && hit == 16'h0000 |=> event_r == 16'h0000) // [R5]
		else $error("read did not clear");
	a_rise_sets_evt: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && $rose(g.cond[0]) && rise_r[0] |=> event_r[0]) // [R13]
		else $error("rise not captured");
	a_sticky_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
		event_r[1] && !g.rd_clr && !g.preset |=> event_r[1]) // [R7]
		else $error("event bit dropped");
endmodule : ser_group
`default_nettype wire

// ### hdl/ser_grp_if.sv
// Bundle between the top and one status group
`timescale 1ns/1ps
`default_nettype none
interface ser_grp_if;
	ser_pkg::ser_word_t cond;
	ser_pkg::ser_word_t wr_data;
	logic               wr_ena;
	logic               wr_fall;
	logic               wr_rise;
	logic               rd_clr;
	logic               preset;
	ser_pkg::ser_word_t event_q;
	ser_pkg::ser_word_t ena_q;
	ser_pkg::ser_word_t fall_q;
	ser_pkg::ser_word_t rise_q;
	logic               summary;
	modport ctl (output cond, wr_data, wr_ena, wr_fall, wr_rise, rd_clr, preset,
		input event_q, ena_q, fall_q, rise_q, summary);
	modport grp (input cond, wr_data, wr_ena, wr_fall, wr_rise, rd_clr, preset,
		output event_q, ena_q, fall_q, rise_q, summary);
endinterface : ser_grp_if
`default_nettype wire

// ### hdl/ser_params.svh
// Constants for the status event reporting block
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

`define SER_WORD_W      16
`define SER_LIVE_MASK   16'h7fff
`define SER_ZERO        16'h0000
`define SER_SEL_W       4
`define SER_SEL_OP_EVT  4'h0
`define SER_SEL_OP_CND  4'h1
`define SER_SEL_OP_ENA  4'h2
`define SER_SEL_OP_FALL 4'h3
`define SER_SEL_OP_RISE 4'h4
`define SER_SEL_QU_EVT  4'h5
`define SER_SEL_QU_CND  4'h6
`define SER_SEL_QU_ENA  4'h7
`define SER_SEL_QU_FALL 4'h8
`define SER_SEL_QU_RISE 4'h9
`define SER_BIT_QUEUE   2
`define SER_BIT_QUES    3
`define SER_BIT_OPER    7

`endif

// ### hdl/ser_pkg.sv
// Types shared by the status event reporting block
package ser_pkg;
	typedef logic [15:0] ser_word_t;
	typedef enum logic [1:0] {
		SER_SLOT_EVT  = 2'h0,
		SER_SLOT_ENA  = 2'h1,
		SER_SLOT_FALL = 2'h2,
		SER_SLOT_RISE = 2'h3
	} ser_slot_t;
endpackage : ser_pkg

// ### hdl/ser_top.sv
// Status event reporting: two groups, command port and status byte
// Functional notes
// R1 - Each group: condition, event, enable, two filters
// R2 - Preset enables queue errors, disables other entries
// R3 - Queue summary reported in status byte bit 2
// R4 - Registers sixteen bits, top bit reads zero
// R5 - Event read returns bits then clears them
// R6 - Event in clearing cycle stays recorded
// R7 - Enabled transition sets sticky event bit
// R8 - Condition read has no side effects
// R9 - Condition bits track live inputs continuously
// R10 - Enabled operation event sets status bit 7
// R11 - Enabled questionable event sets status bit 3
// R12 - Fall filter lets one-to-zero set event
// R13 - Rise filter lets zero-to-one set event
// R14 - Enable and filters read/write, reset zero
// R15 - Preset resets and clears both enable masks
// R16 - Summary is OR of event AND enable
`include "ser_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ser_top (
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic                    clk_en,
	input  wire logic [15:0]             op_cond_pin,
	input  wire logic [15:0]             qu_cond_pin,
	input  wire logic                    queue_nonempty,
	input  wire logic                    cmd_wr,
	input  wire logic                    cmd_rd,
	input  wire logic                    cmd_preset,
	input  wire logic [`SER_SEL_W-1:0]   cmd_sel,
	input  wire logic [15:0]             cmd_wdata,
	output logic [15:0]                  rd_data,
	output logic                         rd_valid,
	output logic [7:0]                   status_byte,
	output logic                         queue_err_only,
	output logic                         reset_req
);
	ser_grp_if op_if ();
	ser_grp_if qu_if ();
	ser_pkg::ser_word_t op_s1_r, op_s2_r, qu_s1_r, qu_s2_r;
	logic qn_s1_r, qn_s2_r;
	logic [15:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] sb_r, sb_nxt;
	logic qerr_r, qerr_nxt, rst_req_r, rst_req_nxt;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			op_s1_r <= `SER_ZERO;
			op_s2_r <= `SER_ZERO;
			qu_s1_r <= `SER_ZERO;
			qu_s2_r <= `SER_ZERO;
			qn_s1_r <= 1'b0;
			qn_s2_r <= 1'b0;
		end
		else if (clk_en)
		begin
			op_s1_r <= op_cond_pin;
			op_s2_r <= op_s1_r;
			qu_s1_r <= qu_cond_pin;
			qu_s2_r <= qu_s1_r;
			qn_s1_r <= queue_nonempty;
			qn_s2_r <= qn_s1_r;
		end
	end

	// Group command steering; condition is live, unlatched
	always_comb
	begin
		op_if.cond    = op_s2_r & `SER_LIVE_MASK; // [R9]
		qu_if.cond    = qu_s2_r & `SER_LIVE_MASK; // [R9]
		op_if.wr_data = cmd_wdata;
		qu_if.wr_data = cmd_wdata;
		op_if.wr_ena  = cmd_wr && cmd_sel == `SER_SEL_OP_ENA; // [R14]
		op_if.wr_fall = cmd_wr && cmd_sel == `SER_SEL_OP_FALL;
		op_if.wr_rise = cmd_wr && cmd_sel == `SER_SEL_OP_RISE;
		qu_if.wr_ena  = cmd_wr && cmd_sel == `SER_SEL_QU_ENA;
		qu_if.wr_fall = cmd_wr && cmd_sel == `SER_SEL_QU_FALL;
		qu_if.wr_rise = cmd_wr && cmd_sel == `SER_SEL_QU_RISE;
		op_if.rd_clr  = cmd_rd && cmd_sel == `SER_SEL_OP_EVT; // [R5]
		qu_if.rd_clr  = cmd_rd && cmd_sel == `SER_SEL_QU_EVT; // [R5]
		op_if.preset  = cmd_preset; // [R15]
		qu_if.preset  = cmd_preset; // [R15]
	end

	ser_group u_op (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.g        (op_if.grp)
	);

	ser_group u_qu (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.g        (qu_if.grp)
	);

	// Read mux, status byte and preset side effects
	always_comb
	begin
		rd_valid_nxt = cmd_rd;
		rd_data_nxt = rd_data_r;
		if (cmd_rd)
		begin
			unique case (cmd_sel)
				`SER_SEL_OP_EVT:  rd_data_nxt = op_if.event_q; // [R5]
				`SER_SEL_OP_CND:  rd_data_nxt = op_if.cond; // [R8]
				`SER_SEL_OP_ENA:  rd_data_nxt = op_if.ena_q;
				`SER_SEL_OP_FALL: rd_data_nxt = op_if.fall_q;
				`SER_SEL_OP_RISE: rd_data_nxt = op_if.rise_q;
				`SER_SEL_QU_EVT:  rd_data_nxt = qu_if.event_q;
				`SER_SEL_QU_CND:  rd_data_nxt = qu_if.cond; // [R8]
				`SER_SEL_QU_ENA:  rd_data_nxt = qu_if.ena_q;
				`SER_SEL_QU_FALL: rd_data_nxt = qu_if.fall_q;
				`SER_SEL_QU_RISE: rd_data_nxt = qu_if.rise_q;
				default:          rd_data_nxt = `SER_ZERO; // Unmapped selects read zero
			endcase
			rd_data_nxt = rd_data_nxt & `SER_LIVE_MASK; // [R4]
		end
		sb_nxt = 8'h00;
		sb_nxt[`SER_BIT_OPER]  = op_if.summary; // [R10]
		sb_nxt[`SER_BIT_QUES]  = qu_if.summary; // [R11]
		sb_nxt[`SER_BIT_QUEUE] = qn_s2_r; // [R3]
		qerr_nxt = cmd_preset ? 1'b1 : qerr_r; // [R2]
		rst_req_nxt = cmd_preset; // [R15]
	end

	// Output registers; status byte lags summaries by one cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rd_data_r <= `SER_ZERO;
			rd_valid_r <= 1'b0;
			sb_r <= 8'h00;
			qerr_r <= 1'b0;
			rst_req_r <= 1'b0;
		end
		else if (clk_en)
		begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			sb_r <= sb_nxt;
			qerr_r <= qerr_nxt;
			rst_req_r <= rst_req_nxt;
		end
	end

	assign rd_data        = rd_data_r;
	assign rd_valid       = rd_valid_r;
	assign status_byte    = sb_r;
	assign queue_err_only = qerr_r;
	assign reset_req      = rst_req_r;

	a_oper_sum_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en |=> status_byte[7] == $past(|(op_if.event_q & op_if.ena_q))) // [R10]
		else $error("operation summary wrong");
	a_ques_sum_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en |=> status_byte[3] == $past(|(qu_if.event_q & qu_if.ena_q))) // [R11]
		else $error("questionable summary wrong");
	a_queue_sum_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en |=> status_byte[2] == $past(qn_s2_r)) // [R3]
		else $error("queue summary wrong");
	a_preset_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && cmd_preset |=> op_if.ena_q == 16'h0000 && qu_if.ena_q == 16'h0000 && reset_req) // [R15]
		else $error("preset left mask");
	a_preset_queue: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && cmd_preset |=> queue_err_only) // [R2]
		else $error("preset queue filter");
	a_cond_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && cmd_rd && cmd_sel == `SER_SEL_OP_CND |=> rd_valid && rd_data == $past(op_if.cond)) // [R8]
		else $error("condition read wrong");
	a_ena_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && cmd_wr && !cmd_preset && cmd_sel == `SER_SEL_OP_ENA
		|=> op_if.ena_q == ($past(cmd_wdata) & `SER_LIVE_MASK)) // [R14]
		else $error("enable write lost");
	a_read_msb_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		!rd_data[15]) // [R4]
		else $error("read top bit set");

	// Strobes answer for one cycle only; a stuck pulse would repeat an instrument reset
	a_rd_valid_pulse: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		clk_en |=> rd_valid == $past(cmd_rd))
		else $error("read valid wrong");
	a_reset_req_pulse: assert property (@(posedge core_clk) disable iff (!rst_b) // [R15]
		clk_en |=> reset_req == $past(cmd_preset))
		else $error("reset request wrong");
	a_spare_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		(status_byte & 8'h73) == 8'h00)
		else $error("spare status bit set");
	a_queue_err_held: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
		queue_err_only |=> queue_err_only)
		else $error("queue filter dropped");

	// Read data holds between reads and carries the event word of the read edge
	a_read_data_held: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		clk_en && !cmd_rd |=> $stable(rd_data))
		else $error("read data moved");
	a_event_read_data: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		clk_en && cmd_rd && cmd_sel == `SER_SEL_OP_EVT
		|=> rd_data == ($past(op_if.event_q) & `SER_LIVE_MASK))
		else $error("event read wrong");
	a_ques_cond_read: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		clk_en && cmd_rd && cmd_sel == `SER_SEL_QU_CND |=> rd_valid && rd_data == $past(qu_if.cond))
		else $error("questionable condition read wrong");
	a_cond_read_pure: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		clk_en && cmd_rd && cmd_sel == `SER_SEL_OP_CND && !cmd_preset
		|=> (op_if.event_q & $past(op_if.event_q)) == $past(op_if.event_q))
		else $error("condition read cleared events");

	// Writes land masked to fifteen bits in the selected register only
	a_ques_ena_write: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
		clk_en && cmd_wr && !cmd_preset && cmd_sel == `SER_SEL_QU_ENA
		|=> qu_if.ena_q == ($past(cmd_wdata) & `SER_LIVE_MASK))
		else $error("questionable enable write lost");
	a_rise_filt_write: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13] [R14]
		clk_en && cmd_wr && !cmd_preset && cmd_sel == `SER_SEL_OP_RISE
		|=> op_if.rise_q == ($past(cmd_wdata) & `SER_LIVE_MASK))
		else $error("rise filter write lost");
	a_fall_filt_write: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12] [R14]
		clk_en && cmd_wr && !cmd_preset && cmd_sel == `SER_SEL_QU_FALL
		|=> qu_if.fall_q == ($past(cmd_wdata) & `SER_LIVE_MASK))
		else $error("fall filter write lost");
endmodule : ser_top
`default_nettype wire

// ### test/ser_top_tb.sv
// Self-checking bench for the status event reporting block
`timescale 1ns/1ps
`default_nettype none
module ser_top_tb;
	logic        core_clk, rst_b, clk_en, queue_nonempty;
	logic        cmd_wr, cmd_rd, cmd_preset;
	logic [15:0] op_cond_pin, qu_cond_pin, cmd_wdata, rd_data, a, b;
	logic [3:0]  cmd_sel;
	logic [7:0]  status_byte;
	logic        rd_valid, queue_err_only, reset_req;
	int          n_fail, cmp_count;
	typedef struct {logic [3:0] sel; logic [15:0] wdata; logic [15:0] exp;} ser_row_t;
	ser_row_t    rows [8];

	ser_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .op_cond_pin(op_cond_pin),
		.qu_cond_pin(qu_cond_pin), .queue_nonempty(queue_nonempty), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_preset(cmd_preset), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
		.rd_valid(rd_valid), .status_byte(status_byte), .queue_err_only(queue_err_only),
		.reset_req(reset_req));

	// Free-running core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	// Compare and count, four-state exact
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Idle cycle after each command keeps strobes from toggling twice in one step
	task automatic wr(input logic [3:0] sel, input logic [15:0] data);
		cmd_wr = 1'b1;
		cmd_sel = sel;
		cmd_wdata = data;
		tick(1);
		cmd_wr = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [3:0] sel, output logic [15:0] val);
		cmd_rd = 1'b1;
		cmd_sel = sel;
		tick(1);
		chk(16'(rd_valid), 16'h0001);
		val = rd_data;
		cmd_rd = 1'b0;
		tick(1);
	endtask : rd

	task automatic rdchk(input logic [3:0] sel, input logic [15:0] exp);
		logic [15:0] v;
		rd(sel, v);
		chk(v, exp);
	endtask : rdchk

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// Main sequence: table of register accesses, then hand-written cases
	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		op_cond_pin = 16'h0000;
		qu_cond_pin = 16'h0000;
		queue_nonempty = 1'b0;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_preset = 1'b0;
		cmd_sel = 4'h0;
		cmd_wdata = 16'h0000;
		n_fail = 0;
		cmp_count = 0;
		rows = '{'{4'h2, 16'hffff, 16'h7fff}, '{4'h3, 16'h8001, 16'h0001}, '{4'h4, 16'h1234, 16'h1234},
			'{4'h7, 16'hffff, 16'h7fff}, '{4'h8, 16'h00f0, 16'h00f0}, '{4'h9, 16'h7ffe, 16'h7ffe},
			'{4'h1, 16'h5555, 16'h0000}, '{4'ha, 16'hffff, 16'h0000}};
		tick(8);
		rst_b = 1'b1;
		tick(1);
		foreach (rows[i])
		begin
			wr(rows[i].sel, rows[i].wdata);
			rdchk(rows[i].sel, rows[i].exp);
		end
		// Second reset mid-run clears every writable mask
		rst_b = 1'b0;
		tick(8);
		rst_b = 1'b1;
		tick(1);
		foreach (rows[i])
			if (i < 6)
				rdchk(rows[i].sel, 16'h0000);
		chk(16'(status_byte), 16'h0000);
		// Rising edge through the rise filter, summary, clearing read
		wr(4'h2, 16'h0001);
		wr(4'h4, 16'h0001);
		op_cond_pin = 16'h8001;
		tick(6);
		rdchk(4'h1, 16'h0001);
		rdchk(4'h1, 16'h0001);
		chk(16'(status_byte[7]), 16'h0001);
		rdchk(4'h0, 16'h0001);
		tick(2);
		chk(16'(status_byte), 16'h0000);
		rdchk(4'h0, 16'h0000);
		// Fall filter only: a rise must not record, a fall must
		wr(4'h7, 16'h0002);
		wr(4'h8, 16'h0002);
		qu_cond_pin = 16'h0002;
		tick(6);
		rdchk(4'h5, 16'h0000);
		qu_cond_pin = 16'h0000;
		tick(6);
		chk(16'(status_byte), 16'h0008);
		rdchk(4'h5, 16'h0002);
		// Toggle at every offset from a clearing read; the event must show in one of two reads
		wr(4'h3, 16'h0001);
		for (int k = 0; k < 6; k++)
		begin
			op_cond_pin[0] = ~op_cond_pin[0];
			tick(k);
			rd(4'h0, a);
			tick(6);
			rd(4'h0, b);
			chk((a | b) & 16'h0001, 16'h0001);
		end
		queue_nonempty = 1'b1;
		tick(4);
		chk(16'(status_byte), 16'h0004);
		// Frozen clock enable ignores a write
		clk_en = 1'b0;
		wr(4'h2, 16'h0f0f);
		clk_en = 1'b1;
		rdchk(4'h2, 16'h0001);
		// Preset clears both enable masks and requests the instrument reset
		cmd_preset = 1'b1;
		tick(1);
		cmd_preset = 1'b0;
		chk(16'(reset_req), 16'h0001);
		chk(16'(queue_err_only), 16'h0001);
		tick(1);
		chk(16'(reset_req), 16'h0000);
		rdchk(4'h2, 16'h0000);
		rdchk(4'h7, 16'h0000);
		give_verdict();
	end
endmodule : ser_top_tb
`default_nettype wire
